// ==== flcs_top.sv ====
// Fuse, lock bit and signature store with working latches
`default_nettype none
// Operation
// - Two lock bits; 1 means unprogrammed, 0 programmed.
// - Lock bits return to 1 only through chip erase.
// - Self-program store enabled over whole flash when its fuse is 0.
// - Debug enable fuse allows readout despite locks; debug link is off while low lock bit is programmed.
// - Mode 1, both locks 1: no restrictions.
// - Mode 2: programming refused, verify allowed, debug link off.
// - Mode 3: programming and verify refused, debug link off.
// - Fuse writes rejected while low lock bit is programmed.
// - Three fuse bytes; programmed reads 0, unprogrammed 1.
// - Extended bit 0 is self-program fuse; bits 7..1 read 1.
// - High byte: reset disable, debug, watchdog, preserve, brown-out.
// - Reset-disable fuse set: changes only via high-voltage mode.
// - Serial enable fuse hidden and fixed in serial program mode.
// - Watchdog forced on disables the watchdog interrupt.
// - Preserve fuse keeps EEPROM through chip erase.
// - Low byte: divide by eight, clock out, start-up, clock source.
// - Chip erase leaves all fuse bytes unchanged.
// - Fuses latched at programming entry; preserve fuse acts at once.
// - Fuses latched into working latches at every power-up.
// - Signature map: 0 id0, 1 trim, 2 id1, 4 id2; rest reserved.
// - Identity bytes readable in both modes even when locked.
// - Trim byte copied to oscillator trim register during reset.
// - Firmware reads config bytes by index within three cycles.
// - Chip erase fills flash and EEPROM with 0xFF.
module flcs_top #(
    parameter logic [7:0] ID_BYTE0 = 8'h5A, // arbitrary value
    parameter logic [7:0] ID_BYTE1 = 8'h3C, // arbitrary value
    parameter logic [7:0] ID_BYTE2 = 8'h66, // arbitrary value
    parameter logic [7:0] TRIM_BYTE = 8'h80
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic progEntry,
    input wire logic progExit,
    input wire logic highVoltageMode,
    input wire logic progLockWrite,
    input wire logic progFuseWrite,
    input wire logic [1:0] progSelect,
    input wire logic [7:0] progData,
    input wire logic progChipErase,
    input wire logic progMemWrite,
    input wire logic progVerifyReq,
    input wire logic progConfigRead,
    input wire logic [5:0] progSigIndex,
    input wire logic progSigRead,
    input wire logic configReadArm,
    input wire logic signatureReadArm,
    input wire logic loadStrobe,
    input wire logic [5:0] loadIndex,
    input wire logic watchdogExpire,
    output logic [7:0] progReadData,
    output logic progReadValid,
    output logic [7:0] loadData,
    output logic loadValid,
    output logic memWriteGrant,
    output logic verifyGrant,
    output logic memoryEraseStrobe,
    output logic eepromEraseStrobe,
    output logic [7:0] eraseFillValue,
    output logic debugLinkEnable,
    output logic debugReadoutAllowed,
    output logic storeInstrEnable,
    output logic resetPinDisabled,
    output logic watchdogForcedOn,
    output logic watchdogIrq,
    output logic [2:0] brownoutLevel,
    output logic clockDivideByEight,
    output logic clockToPin,
    output logic [1:0] startupTime,
    output logic [3:0] clockSource,
    output logic [7:0] oscillator_trim_register,
    output logic inProgramming
);
    logic [7:0] lock_protection_byte;
    logic [7:0] extended_config_byte;
    logic [7:0] high_config_byte;
    logic [7:0] low_config_byte;
    logic [7:0] latchExt;
    logic [7:0] latchHigh;
    logic [7:0] latchLow;
    logic latchValid;
    logic [1:0] readArmCount;
    logic readArmSig;
    flcs_pkg::flcs_state_t state;
    flcs_pkg::flcs_state_t next_state;
    logic lock_bit_low;
    logic lock_bit_high;
    logic fuseWriteOk;
    logic lockWriteOk;
    logic serialHidesSpen;
    logic [7:0] fuseWriteData;
    logic [7:0] highStored;

    assign lock_bit_low = lock_protection_byte[flcs_pkg::LOCK_LOW_POS];
    assign lock_bit_high = lock_protection_byte[flcs_pkg::LOCK_HIGH_POS];

    // Nonvolatile cells
    flcs_nv_byte #(.INIT(flcs_pkg::LOCK_RESET)) u_lock (
        .clk(clk),
        .nrst(nrst),
        .writeEn(lockWriteOk),
        .writeData(progData & lock_protection_byte),
        .eraseEn(progChipErase && state == flcs_pkg::FLCS_PROG),
        .value(lock_protection_byte)
    );
    flcs_nv_byte #(.INIT(flcs_pkg::EXT_RESET)) u_ext (
        .clk(clk),
        .nrst(nrst),
        .writeEn(fuseWriteOk && progSelect == flcs_pkg::RD_EXT),
        .writeData({7'h7F, progData[flcs_pkg::SELFPRG_POS]}),
        .eraseEn(1'b0),
        .value(extended_config_byte)
    );
    flcs_nv_byte #(.INIT(flcs_pkg::HIGH_RESET)) u_high (
        .clk(clk),
        .nrst(nrst),
        .writeEn(fuseWriteOk && progSelect == flcs_pkg::RD_HIGH),
        .writeData(fuseWriteData),
        .eraseEn(1'b0),
        .value(highStored)
    );
    flcs_nv_byte #(.INIT(flcs_pkg::LOW_RESET)) u_low (
        .clk(clk),
        .nrst(nrst),
        .writeEn(fuseWriteOk && progSelect == flcs_pkg::RD_LOW),
        .writeData(progData),
        .eraseEn(1'b0),
        .value(low_config_byte)
    );
    assign high_config_byte = highStored;

    // Write qualification
    assign serialHidesSpen = inProgramming && !highVoltageMode;
    always_comb begin
        fuseWriteData = progData;
        if (serialHidesSpen) begin
            fuseWriteData[flcs_pkg::SPEN_POS] =
                highStored[flcs_pkg::SPEN_POS];
        end
    end
    assign fuseWriteOk = progFuseWrite && inProgramming
        && lock_bit_low
        && (highVoltageMode
            || highStored[flcs_pkg::RSTDIS_POS]);
    assign lockWriteOk = progLockWrite && inProgramming
        && (highVoltageMode || highStored[flcs_pkg::RSTDIS_POS]);

    // Programming mode sequencing
    always_comb begin
        next_state = state;
        unique case (state)
            flcs_pkg::FLCS_IDLE: if (progEntry) begin
                next_state = flcs_pkg::FLCS_PROG;
            end
            flcs_pkg::FLCS_PROG: if (progExit) begin
                next_state = flcs_pkg::FLCS_IDLE;
            end else if (progChipErase) begin
                next_state = flcs_pkg::FLCS_ERASE;
            end
            flcs_pkg::FLCS_ERASE: next_state = flcs_pkg::FLCS_PROG;
            default: next_state = flcs_pkg::FLCS_IDLE;
        endcase
    end
    always_ff @(posedge clk) begin
        if (!nrst) begin
            state <= flcs_pkg::FLCS_IDLE;
        end else begin
            state <= next_state;
        end
    end
    assign inProgramming = state != flcs_pkg::FLCS_IDLE;

    // Working latches: power-up and programming entry
    always_ff @(posedge clk) begin
        if (!nrst) begin
            latchValid <= 1'b0;
            latchExt <= flcs_pkg::EXT_RESET;
            latchHigh <= flcs_pkg::HIGH_RESET;
            latchLow <= flcs_pkg::LOW_RESET;
        end else if (!latchValid
            || (state == flcs_pkg::FLCS_IDLE && progEntry)) begin
            latchValid <= 1'b1;
            latchExt <= extended_config_byte;
            latchHigh <= highStored;
            latchLow <= low_config_byte;
        end
    end

    // Lock mode decode
    always_comb begin
        memWriteGrant = progMemWrite && inProgramming
            && lock_bit_low && lock_bit_high;
        verifyGrant = progVerifyReq && inProgramming
            && (lock_bit_high || lock_bit_low);
        debugLinkEnable = !latchHigh[flcs_pkg::DBGEN_POS]
            && lock_bit_low;
        debugReadoutAllowed = !latchHigh[flcs_pkg::DBGEN_POS];
    end

    // Chip erase
    always_ff @(posedge clk) begin
        if (!nrst) begin
            memoryEraseStrobe <= 1'b0;
            eepromEraseStrobe <= 1'b0;
        end else begin
            memoryEraseStrobe <= state == flcs_pkg::FLCS_ERASE;
            eepromEraseStrobe <= state == flcs_pkg::FLCS_ERASE
                && highStored[flcs_pkg::EEKEEP_POS];
        end
    end
    assign eraseFillValue = flcs_pkg::ERASED_BYTE;

    // Latched fuse outputs
    assign storeInstrEnable = !latchExt[flcs_pkg::SELFPRG_POS];
    assign resetPinDisabled = !latchHigh[flcs_pkg::RSTDIS_POS];
    assign watchdogForcedOn = !latchHigh[flcs_pkg::WDON_POS];
    assign watchdogIrq = watchdogExpire && !watchdogForcedOn;
    assign brownoutLevel = latchHigh[2:0];
    assign clockDivideByEight = !latchLow[7];
    assign clockToPin = !latchLow[6];
    assign startupTime = latchLow[5:4];
    assign clockSource = latchLow[3:0];

    // Oscillator trim loaded during reset
    always_ff @(posedge clk) begin
        if (!nrst) begin
            oscillator_trim_register <= TRIM_BYTE;
        end
    end

    // Signature lookup
    function automatic logic [7:0] sigByte(input logic [5:0] idx);
        unique case (idx)
            flcs_pkg::SIG_ID0: sigByte = ID_BYTE0;
            flcs_pkg::SIG_TRIM: sigByte = TRIM_BYTE;
            flcs_pkg::SIG_ID1: sigByte = ID_BYTE1;
            flcs_pkg::SIG_ID2: sigByte = ID_BYTE2;
            default: sigByte = 8'hFF;
        endcase
    endfunction

    function automatic logic [7:0] cfgByte(input logic [1:0] sel,
        input logic [7:0] lockB, input logic [7:0] extB,
        input logic [7:0] highB, input logic [7:0] lowB);
        unique case (sel)
            flcs_pkg::RD_LOW: cfgByte = lowB;
            flcs_pkg::RD_LOCK: cfgByte = lockB;
            flcs_pkg::RD_EXT: cfgByte = extB;
            flcs_pkg::RD_HIGH: cfgByte = highB;
        endcase
    endfunction

    // Programmer reads
    always_ff @(posedge clk) begin
        if (!nrst) begin
            progReadData <= 8'h00;
            progReadValid <= 1'b0;
        end else begin
            progReadValid <= inProgramming && (progSigRead || progConfigRead);
            if (inProgramming && progSigRead) begin
                progReadData <= sigByte(progSigIndex);
            end else if (inProgramming && progConfigRead) begin
                progReadData <= cfgByte(progSelect, lock_protection_byte,
                    extended_config_byte, highStored, low_config_byte);
                if (serialHidesSpen && progSelect == flcs_pkg::RD_HIGH) begin
                    progReadData[flcs_pkg::SPEN_POS] <= 1'b1;
                end
            end
        end
    end

    // Firmware read window
    always_ff @(posedge clk) begin
        if (!nrst) begin
            readArmCount <= 2'h0;
            readArmSig <= 1'b0;
        end else if (configReadArm || signatureReadArm) begin
            readArmCount <= flcs_pkg::READ_WINDOW;
            readArmSig <= signatureReadArm;
        end else if (loadStrobe) begin
            readArmCount <= 2'h0;
        end else if (readArmCount != 2'h0) begin
            readArmCount <= readArmCount - 2'h1;
        end
    end
    always_ff @(posedge clk) begin
        if (!nrst) begin
            loadData <= 8'h00;
            loadValid <= 1'b0;
        end else begin
            loadValid <= loadStrobe && readArmCount != 2'h0;
            if (loadStrobe && readArmCount != 2'h0) begin
                loadData <= readArmSig ? sigByte(loadIndex)
                    : cfgByte(loadIndex[1:0], lock_protection_byte,
                    extended_config_byte, highStored,
                    low_config_byte);
            end
        end
    end

    a_lock_no_set: assert property (
        @(posedge clk) disable iff (!nrst)
        (state != flcs_pkg::FLCS_ERASE && !$past(lock_protection_byte[0]))
        |=> !lock_protection_byte[0] || $past(state) == flcs_pkg::FLCS_ERASE
        || $past(progChipErase)) else $error("lock bit raised");
    a_fuse_lock_block: assert property (
        @(posedge clk) disable iff (!nrst)
        (!lock_bit_low && progFuseWrite) |=> $stable(low_config_byte)
        && $stable(highStored) && $stable(extended_config_byte))
        else $error("fuse write in lock");
    a_mode3_verify: assert property (
        @(posedge clk) disable iff (!nrst)
        (!lock_bit_low && !lock_bit_high) |-> !verifyGrant)
        else $error("verify in mode 3");
    a_mode2_write: assert property (
        @(posedge clk) disable iff (!nrst)
        !lock_bit_low |-> !memWriteGrant && !debugLinkEnable)
        else $error("write in mode 2");
    a_wdt_irq_off: assert property (
        @(posedge clk) disable iff (!nrst)
        watchdogForcedOn |-> !watchdogIrq) else $error("wdt irq");
    a_erase_keeps: assert property (
        @(posedge clk) disable iff (!nrst)
        state == flcs_pkg::FLCS_ERASE |=> $stable(low_config_byte)
        && $stable(highStored) && $stable(extended_config_byte))
        else $error("fuse erased");
    a_read_window: assert property (
        @(posedge clk) disable iff (!nrst)
        (configReadArm ##1 !loadStrobe [*3] ##1 loadStrobe) |=> !loadValid)
        else $error("late load served");
    a_latch_hold: assert property (
        @(posedge clk) disable iff (!nrst)
        (inProgramming && $past(inProgramming)) |-> $stable(latchHigh))
        else $error("latch moved");
    a_trim_load: assert property (
        @(posedge clk) !nrst |=> oscillator_trim_register == TRIM_BYTE)
        else $error("trim not loaded");
    a_erase_strobe: assert property (
        @(posedge clk) disable iff (!nrst)
        state == flcs_pkg::FLCS_ERASE |=> memoryEraseStrobe)
        else $error("erase strobe missing");
    a_spen_hidden: assert property (
        @(posedge clk) disable iff (!nrst)
        (serialHidesSpen && progConfigRead && !progSigRead
        && progSelect == flcs_pkg::RD_HIGH)
        |=> progReadData[flcs_pkg::SPEN_POS])
        else $error("serial enable fuse visible");
    c_erase: cover property (@(posedge clk) state == flcs_pkg::FLCS_ERASE);
    c_load: cover property (@(posedge clk) loadValid);
    c_prog_read: cover property (@(posedge clk) progReadValid);
    c_load_refused: cover property (@(posedge clk)
        configReadArm ##4 loadStrobe);
    c_lock_mode3: cover property (@(posedge clk)
        !lock_bit_low && !lock_bit_high);
endmodule
`default_nettype wire

// ==== flcs_pkg.sv ====
// Package of constants for the fuse and lock configuration store
`default_nettype none
package flcs_pkg;
    localparam logic [7:0] LOCK_RESET = 8'hFF;
    localparam logic [7:0] EXT_RESET = 8'hFF;
    localparam logic [7:0] HIGH_RESET = 8'hDF;
    localparam logic [7:0] LOW_RESET = 8'h62;
    localparam logic [7:0] ERASED_BYTE = 8'hFF;
    localparam int LOCK_LOW_POS = 0;
    localparam int LOCK_HIGH_POS = 1;
    localparam int SELFPRG_POS = 0;
    localparam int RSTDIS_POS = 7;
    localparam int DBGEN_POS = 6;
    localparam int SPEN_POS = 5;
    localparam int WDON_POS = 4;
    localparam int EEKEEP_POS = 3;
    localparam logic [1:0] RD_LOW = 2'h0;
    localparam logic [1:0] RD_LOCK = 2'h1;
    localparam logic [1:0] RD_EXT = 2'h2;
    localparam logic [1:0] RD_HIGH = 2'h3;
    localparam logic [5:0] SIG_ID0 = 6'h00;
    localparam logic [5:0] SIG_TRIM = 6'h01;
    localparam logic [5:0] SIG_ID1 = 6'h02;
    localparam logic [5:0] SIG_ID2 = 6'h04;
    localparam logic [5:0] SIG_LAST = 6'h2A;
    localparam logic [1:0] READ_WINDOW = 2'h3;
    typedef enum logic [1:0] {
        FLCS_IDLE = 2'b00,
        FLCS_PROG = 2'b01,
        FLCS_ERASE = 2'b11
    } flcs_state_t;
endpackage
`default_nettype wire

// ==== flcs_nv_byte.sv ====
// One nonvolatile byte cell with load and erase-to-ones
`default_nettype none
module flcs_nv_byte #(
    parameter logic [7:0] INIT = 8'hFF
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic writeEn,
    input wire logic [7:0] writeData,
    input wire logic eraseEn,
    output logic [7:0] value
);
    // Cell keeps content across reset; only writes and erase alter it
    logic loaded = 1'b0;
    always_ff @(posedge clk) begin
        if (!loaded) begin
            value <= INIT;
        end else if (eraseEn) begin
            value <= 8'hFF;
        end else if (writeEn) begin
            value <= writeData;
        end
    end
    always_ff @(posedge clk) begin
        if (nrst) begin
            loaded <= 1'b1;
        end
    end
endmodule
`default_nettype wire

// ==== flcs_programmer.sv ====
// Programmer model driving the programming side of the store
`default_nettype none
module flcs_programmer (
    input wire logic clk,
    output logic progEntry,
    output logic progExit,
    output logic highVoltageMode,
    output logic progLockWrite,
    output logic progFuseWrite,
    output logic [1:0] progSelect,
    output logic [7:0] progData,
    output logic progChipErase,
    output logic progMemWrite,
    output logic progVerifyReq,
    output logic progConfigRead,
    output logic [5:0] progSigIndex,
    output logic progSigRead
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        {progEntry, progExit, highVoltageMode, progLockWrite} = 4'h0;
        {progFuseWrite, progChipErase, progMemWrite, progVerifyReq} = 4'h0;
        {progConfigRead, progSigRead} = 2'h0;
        progSelect = 2'h0;
        progData = 8'h00;
        progSigIndex = 6'h00;
    end
    // One command, raised after a falling edge; strobes held one cycle, high-voltage and request levels kept
    task automatic op(input int kind, input logic [1:0] s,
                      input logic [7:0] d);
        @(negedge clk);
        progSelect = s;
        progData = d;
        progSigIndex = d[5:0];
        case (kind)
            0: progEntry = 1'b1;
            1: progExit = 1'b1;
            2: progLockWrite = 1'b1;
            3: progFuseWrite = 1'b1;
            4: progChipErase = 1'b1;
            5: progConfigRead = 1'b1;
            6: progSigRead = 1'b1;
            7: highVoltageMode = d[0];
            default: {progMemWrite, progVerifyReq} = d[1:0];
        endcase
        @(negedge clk);
        {progEntry, progExit, progLockWrite, progFuseWrite} = 4'h0;
        {progChipErase, progConfigRead, progSigRead} = 3'h0;
        // Released qualifiers stop showing the last value
        progData = ~d;
        progSelect = ~s;
        progSigIndex = ~d[5:0];
    endtask
endmodule
`default_nettype wire

// ==== flcs_top_tb.sv ====
// Self-checking bench for the fuse and lock configuration store
`default_nettype none
module flcs_top_tb;
    timeunit 1ns;
    timeprecision 1ns;
    // Identity values are arbitrary
    localparam logic [7:0] ID0 = 8'h21;
    localparam logic [7:0] ID1 = 8'h43;
    localparam logic [7:0] ID2 = 8'h65;
    localparam logic [7:0] TRIM = 8'h9C;
    logic clk, nrst, configReadArm, signatureReadArm, loadStrobe;
    logic watchdogExpire, progEntry, progExit, highVoltageMode;
    logic progLockWrite, progFuseWrite, progChipErase, progMemWrite;
    logic progVerifyReq, progConfigRead, progSigRead, inProgramming;
    logic progReadValid, loadValid, memWriteGrant, verifyGrant;
    logic memoryEraseStrobe, eepromEraseStrobe, debugLinkEnable;
    logic debugReadoutAllowed, storeInstrEnable, resetPinDisabled;
    logic watchdogForcedOn, watchdogIrq, clockDivideByEight, clockToPin;
    logic [1:0] progSelect, startupTime;
    logic [5:0] progSigIndex, loadIndex;
    logic [7:0] progData, progReadData, loadData, eraseFillValue;
    logic [7:0] oscillator_trim_register;
    logic [2:0] brownoutLevel;
    logic [3:0] clockSource;
    logic [7:0] progQ[$];
    logic [7:0] loadQ[$];
    logic [31:0] rngState = 32'h0000_6812;
    int n_errors = 0;
    int compares = 0;

    flcs_top #(.ID_BYTE0(ID0), .ID_BYTE1(ID1), .ID_BYTE2(ID2),
        .TRIM_BYTE(TRIM)) dut (.clk, .nrst, .progEntry, .progExit,
        .highVoltageMode, .progLockWrite, .progFuseWrite, .progSelect,
        .progData, .progChipErase, .progMemWrite, .progVerifyReq,
        .progConfigRead, .progSigIndex, .progSigRead, .configReadArm,
        .signatureReadArm, .loadStrobe, .loadIndex, .watchdogExpire,
        .progReadData, .progReadValid, .loadData, .loadValid,
        .memWriteGrant, .verifyGrant, .memoryEraseStrobe,
        .eepromEraseStrobe, .eraseFillValue, .debugLinkEnable,
        .debugReadoutAllowed, .storeInstrEnable, .resetPinDisabled,
        .watchdogForcedOn, .watchdogIrq, .brownoutLevel,
        .clockDivideByEight, .clockToPin, .startupTime, .clockSource,
        .oscillator_trim_register, .inProgramming);

    flcs_programmer prog (.clk, .progEntry, .progExit, .highVoltageMode,
        .progLockWrite, .progFuseWrite, .progSelect, .progData,
        .progChipErase, .progMemWrite, .progVerifyReq, .progConfigRead,
        .progSigIndex, .progSigRead);

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    function automatic logic [7:0] rnd();
        rngState ^= rngState << 13;
        rngState ^= rngState >> 17;
        rngState ^= rngState << 5;
        return rngState[7:0];
    endfunction

    task automatic fail(input string msg);
        n_errors++;
        $display("ERROR %0t %s", $time, msg);
    endtask
    task automatic cmp_byte(input logic [7:0] g, e, input string what);
        compares++;
        if (g !== e) fail($sformatf("%s got %h exp %h", what, g, e));
    endtask
    task automatic cmp_bit(input logic g, e, input string what);
        compares++;
        if (g !== e) fail($sformatf("%s got %b exp %b", what, g, e));
    endtask
    task automatic wait_n(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic rd(input logic [1:0] s, input logic [7:0] e);
        progQ.push_back(e);
        prog.op(5, s, 8'h00);
    endtask
    task automatic sig(input logic [5:0] i, input logic [7:0] e);
        progQ.push_back(e);
        prog.op(6, 2'h0, {2'h0, i});
    endtask
    task automatic fw(input logic s, input logic [5:0] i, input int gap,
                      input logic [7:0] e);
        if (gap <= 3) loadQ.push_back(e);
        @(negedge clk);
        configReadArm = !s;
        signatureReadArm = s;
        @(negedge clk);
        configReadArm = 1'b0;
        signatureReadArm = 1'b0;
        repeat (gap - 1) @(negedge clk);
        loadStrobe = 1'b1;
        loadIndex = i;
        @(negedge clk);
        loadStrobe = 1'b0;
        loadIndex = ~i;
        wait_n(2);
    endtask
    task automatic erase(input logic ee);
        int k = 0;
        prog.op(4, 2'h0, 8'h00);
        while (memoryEraseStrobe !== 1'b1 && k < 8) begin
            @(negedge clk);
            k++;
        end
        cmp_bit(k == 1, 1'b1, "erase latency");
        cmp_bit(eepromEraseStrobe, ee, "eeprom erase");
        cmp_byte(eraseFillValue, flcs_pkg::ERASED_BYTE, "fill");
    endtask
    task automatic stop_test();
        $display("compares %0d errors %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // Answers are matched in order against the noted expectations
    always @(negedge clk) begin
        if (progReadValid === 1'b1) begin
            if (progQ.size() == 0) fail("unexpected programming read");
            else cmp_byte(progReadData, progQ.pop_front(), "prog");
        end
        if (loadValid === 1'b1) begin
            if (loadQ.size() == 0) fail("unexpected firmware read");
            else cmp_byte(loadData, loadQ.pop_front(), "load");
        end
    end

    initial begin
        wait_n(3000);
        fail("timeout");
        stop_test();
    end

    initial begin
        logic [7:0] lowVal;
        {nrst, configReadArm, signatureReadArm, loadStrobe} = 4'h0;
        loadIndex = 6'h00;
        watchdogExpire = 1'b1;
        wait_n(5);
        nrst = 1'b1;
        wait_n(2);
        cmp_byte(oscillator_trim_register, TRIM, "trim");
        cmp_bit(storeInstrEnable, 1'b0, "store enable");
        cmp_bit(watchdogIrq, 1'b1, "wdog irq");
        cmp_bit(debugReadoutAllowed, 1'b0, "debug readout");
        cmp_bit(clockDivideByEight, 1'b1, "div8 default");
        cmp_byte({4'h0, clockSource}, 8'h02, "clock source");
        prog.op(0, 2'h0, 8'h00);
        wait_n(1);
        cmp_bit(inProgramming, 1'b1, "in programming");
        rd(flcs_pkg::RD_LOW, flcs_pkg::LOW_RESET);
        rd(flcs_pkg::RD_HIGH, 8'hFF);
        rd(flcs_pkg::RD_EXT, flcs_pkg::EXT_RESET);
        rd(flcs_pkg::RD_LOCK, flcs_pkg::LOCK_RESET);
        sig(flcs_pkg::SIG_ID0, ID0);
        sig(flcs_pkg::SIG_TRIM, TRIM);
        sig(flcs_pkg::SIG_ID1, ID1);
        sig(6'h03, 8'hFF);
        sig(flcs_pkg::SIG_ID2, ID2);
        for (int i = 0; i < 3; i++)
            sig(6'h05 + 6'(rnd() % 8'd38), 8'hFF);
        erase(1'b1);
        prog.op(3, flcs_pkg::RD_HIGH, 8'hFB);
        prog.op(7, 2'h0, 8'h01);
        rd(flcs_pkg::RD_HIGH, 8'hDB);
        prog.op(3, flcs_pkg::RD_HIGH, 8'h07);
        rd(flcs_pkg::RD_HIGH, 8'h07);
        cmp_bit(watchdogForcedOn, 1'b0, "wdog on early");
        erase(1'b0);
        rd(flcs_pkg::RD_HIGH, 8'h07);
        lowVal = rnd();
        prog.op(3, flcs_pkg::RD_LOW, lowVal);
        rd(flcs_pkg::RD_LOW, lowVal);
        prog.op(3, flcs_pkg::RD_EXT, 8'h00);
        rd(flcs_pkg::RD_EXT, 8'hFE);
        prog.op(1, 2'h0, 8'h00);
        prog.op(0, 2'h0, 8'h00);
        wait_n(3);
        cmp_bit(storeInstrEnable, 1'b1, "store enable");
        cmp_bit(watchdogForcedOn, 1'b1, "wdog on");
        cmp_bit(watchdogIrq, 1'b0, "wdog irq");
        cmp_bit(resetPinDisabled, 1'b1, "reset pin");
        cmp_bit(debugReadoutAllowed, 1'b1, "debug readout");
        cmp_bit(debugLinkEnable, 1'b1, "debug link");
        cmp_byte({4'h0, clockSource}, {4'h0, lowVal[3:0]}, "clk src");
        cmp_byte({6'h0, startupTime}, {6'h0, lowVal[5:4]}, "startup");
        cmp_bit(clockToPin, !lowVal[6], "clock out");
        cmp_bit(clockDivideByEight, !lowVal[7], "div8");
        cmp_byte({5'h0, brownoutLevel}, 8'h07, "brownout");
        prog.op(7, 2'h0, 8'h00);
        prog.op(3, flcs_pkg::RD_LOW, ~lowVal);
        prog.op(7, 2'h0, 8'h01);
        rd(flcs_pkg::RD_LOW, lowVal);
        prog.op(8, 2'h0, 8'h03);
        cmp_bit(memWriteGrant, 1'b1, "write grant");
        cmp_bit(verifyGrant, 1'b1, "verify grant");
        prog.op(2, flcs_pkg::RD_LOCK, 8'hFE); // Fuses final first
        rd(flcs_pkg::RD_LOCK, 8'hFE);
        cmp_bit(memWriteGrant, 1'b0, "write grant");
        cmp_bit(verifyGrant, 1'b1, "verify grant");
        cmp_bit(debugLinkEnable, 1'b0, "debug link");
        prog.op(3, flcs_pkg::RD_LOW, ~lowVal);
        rd(flcs_pkg::RD_LOW, lowVal);
        prog.op(2, flcs_pkg::RD_LOCK, 8'hFF);
        rd(flcs_pkg::RD_LOCK, 8'hFE);
        sig(flcs_pkg::SIG_ID1, ID1);
        erase(1'b0);
        rd(flcs_pkg::RD_LOCK, 8'hFF);
        rd(flcs_pkg::RD_LOW, lowVal);
        prog.op(2, flcs_pkg::RD_LOCK, 8'hFC);
        cmp_bit(verifyGrant, 1'b0, "verify grant");
        cmp_bit(memWriteGrant, 1'b0, "write grant");
        sig(flcs_pkg::SIG_ID2, ID2);
        prog.op(1, 2'h0, 8'h00);
        wait_n(2);
        fw(1'b0, 6'(flcs_pkg::RD_LOW), 3, lowVal);
        fw(1'b0, 6'(flcs_pkg::RD_LOCK), 1, 8'hFC);
        fw(1'b0, 6'(flcs_pkg::RD_EXT), 2, 8'hFE);
        fw(1'b0, 6'(flcs_pkg::RD_HIGH), 3, 8'h07);
        fw(1'b0, 6'(flcs_pkg::RD_LOW), 4, 8'h00);
        fw(1'b1, flcs_pkg::SIG_TRIM, 2, TRIM);
        nrst = 1'b0;
        wait_n(2);
        nrst = 1'b1;
        wait_n(2);
        cmp_byte(oscillator_trim_register, TRIM, "trim");
        cmp_bit(watchdogForcedOn, 1'b1, "wdog on");
        wait_n(4);
        if (progQ.size() + loadQ.size() != 0) fail("missing answers");
        stop_test();
    end
endmodule
`default_nettype wire
